// [design/tbf_defines.svh]
// Constants of the tape block format decoder: mark codes, zone lengths,
// instruction fields and buffer sizes. Included wherever the macros are used.
`ifndef TBF_DEFINES_SVH
`define TBF_DEFINES_SVH
// Four-line mark-track codes
`define TBF_MK_END 4'h0
`define TBF_MK_INTER 4'hF
`define TBF_MK_FWD 4'hE
`define TBF_MK_REV 4'h7
`define TBF_MK_GUARD 4'h2
`define TBF_MK_DATA 4'h9
`define TBF_MK_FINAL 4'hB
`define TBF_MK_CHECK 4'h1
// Word and block layout
`define TBF_WORD_W 12
`define TBF_LINE_W 3
`define TBF_PULSES 5
`define TBF_DATA_WORDS 8'hFF
`define TBF_CHECK_LAST 2'h2
`define TBF_INTER_WORDS 3'h5
`define TBF_FRONT_END_WORDS 13'h0400
`define TBF_FIRST_INTER_WORDS 13'h1000
`define TBF_BACK_END_WORDS 13'h0800
`define TBF_RUN_W 13
// Fields of the first instruction word
`define TBF_IW_OP_LSB 0
`define TBF_IW_UNIT_LSB 3
`define TBF_IW_REV 6
`define TBF_IW_IBZ 7
`define TBF_IW_ENDREV 8
// Operation codes, one octal digit
`define TBF_OPC_READ 3'h0
`define TBF_OPC_CHECK 3'h1
`define TBF_OPC_WRITE 3'h4
`define TBF_OPC_WCG 3'h5
// Read buffer
`define TBF_FIFO_DEPTH 16
`endif

// [design/tbf_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; a frozen clock enable holds all state.
`timescale 1ns/10ps
`default_nettype none
module tbf_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// Filling side
	tbf_stream_if.snk in_s,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} tbf_fifo_regs_t;
	tbf_fifo_regs_t s;
	tbf_fifo_regs_t next_s;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// Handshakes; full and empty come straight from the count
	assign in_s.ready = (s.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s.cnt != '0);
	assign out_data = mem[s.rp];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_valid && out_ready;

	// Pointer and count update
	always_comb
	begin
		next_s = s;
		if (push)
			next_s.wp = s.wp + 1'b1;
		if (pop)
			next_s.rp = s.rp + 1'b1;
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else if (clk_en)
			s <= next_s;
	end

	// Storage has no reset; empty count hides stale words
	always_ff @(posedge clk_sys)
	begin
		if (clk_en && push)
			mem[s.wp] <= in_s.data;
	end
endmodule
`default_nettype wire

// [design/tbf_mark_decoder.sv]
// Decoder from the four-bit mark window to a mark kind.
// Assumes the caller only uses the result on a word boundary.
`timescale 1ns/10ps
`default_nettype none
`include "tbf_defines.svh"
module tbf_mark_decoder (
	// Window contents
	input wire logic [3:0] window,
	// Decoded mark kind
	output var tbf_pkg::tbf_mark_t mark
);
	// Unknown codes fall to a bad mark so no zone logic reacts
	always_comb
	begin
		case (window)
			`TBF_MK_FWD: mark = tbf_pkg::MK_FWD; // RULE1
			`TBF_MK_REV: mark = tbf_pkg::MK_REV; // RULE1
			`TBF_MK_FINAL: mark = tbf_pkg::MK_FINAL; // RULE1
			`TBF_MK_END: mark = tbf_pkg::MK_END; // RULE2
			`TBF_MK_INTER: mark = tbf_pkg::MK_INTER; // RULE2
			`TBF_MK_GUARD: mark = tbf_pkg::MK_GUARD; // RULE2
			`TBF_MK_DATA: mark = tbf_pkg::MK_DATA; // RULE2
			`TBF_MK_CHECK: mark = tbf_pkg::MK_CHECK; // RULE2
			default: mark = tbf_pkg::MK_BAD;
		endcase
	end
endmodule
`default_nettype wire

// [design/tbf_pkg.sv]
// Types of the tape block format decoder.
// Assumes tbf_defines.svh is reachable on the include path.
`include "tbf_defines.svh"
package tbf_pkg;
	typedef enum logic [3:0] {MK_END, MK_INTER, MK_FWD, MK_REV, MK_GUARD,
		MK_DATA, MK_FINAL, MK_CHECK, MK_BAD} tbf_mark_t;
	typedef enum logic [2:0] {ST_IDLE, ST_SECOND, ST_SEARCH, ST_ARMED,
		ST_XFER, ST_CHECK} tbf_state_t;
	typedef enum logic [2:0] {OP_NONE, OP_READ, OP_CHECK, OP_WRITE,
		OP_WCG} tbf_op_t;
	typedef logic [`TBF_WORD_W-1:0] tbf_word_t;
endpackage

// [design/tbf_stream_if.sv]
// Valid/ready word stream between the framer and its read buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface tbf_stream_if #(parameter int W = 12);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [design/tbf_top.sv]
// Tape block format decoder: samples the timing, mark and data channels,
// frames blocks and moves data words between tape and processor.
// Assumes tape channels are asynchronous; processor ports are on clk_sys.
//
// Summary of operation
// (RULE1) Decode forward block 1110, reverse block 0111, final 1011.
// (RULE2) Decode end 0000, interblock 1111, guard 0010, data 1001, check 0001.
// (RULE3) Every tape word spans four consecutive lines.
// (RULE4) A block starts with forward mark carrying a 12-bit block number.
// (RULE5) One guard word follows the number; transfer mode switches there.
// (RULE6) A block holds 255 data words then one final word.
// (RULE7) The final mark tells the decoder the data portion has ended.
// (RULE8) Three check words follow; first is complemented data sum.
// (RULE9) Writers are switched off during the check words.
// (RULE10) A reverse block mark identifies the block when searching backwards.
// (RULE11) Data is true binary; checksum is recorded complemented.
// (RULE12) Interblock mark signals the processor when enabled.
// (RULE13) Zones: front end 1024, first interblock 4096, back end 2048.
// (RULE14) Five tape pulses per line synchronise all operations.
// (RULE15) Window register feeds decoder driving motion and state control.
// (RULE16) Motion control selects one transport and its direction.
// (RULE17) First instruction word to instruction register, second to target.
// (RULE18) Octal decode of the instruction selects the operation.
// (RULE19) Read assembles 12 bits from four 3-bit lines.
// (RULE20) On a block mark the buffer holds that block's number.
// (RULE21) An end zone reverses motion or stops the transport.
// (RULE22) One mark bit per line enters window; decode after fourth.
// (RULE23) Checksum is 12 bits, cleared at block start, sums each word.
`timescale 1ns/10ps
`default_nettype none
`include "tbf_defines.svh"
module tbf_top (
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// Tape read channels
	input wire logic timing_channel,
	input wire logic mark_channel,
	input wire logic [2:0] data_channel,
	// Tape write channels
	output logic [2:0] write_bits,
	output logic write_enable,
	// Transport control
	output logic [2:0] unit_select,
	output logic reverse,
	output logic motion_go,
	// Instruction from processor
	input wire logic instr_valid,
	input wire logic [11:0] instr_word,
	output logic instr_ready,
	// Words to write
	input wire logic [11:0] write_word,
	output logic write_take,
	// Words read
	output logic read_valid,
	input wire logic read_ready,
	output logic [11:0] read_word,
	// Status
	output logic [11:0] block_number,
	output logic interblock_event,
	output logic check_error,
	output logic format_error,
	output logic overrun,
	output logic first_gap,
	output logic op_done
);
	typedef struct packed {
		logic [1:0] t_sync;
		logic t_prev;
		logic [1:0] m_sync;
		logic [2:0] d_s1;
		logic [2:0] d_s2;
		logic [`TBF_PULSES-1:0] pulse;
		logic [3:0] window;
		logic [1:0] line_cnt;
		tbf_pkg::tbf_word_t asm_word;
		tbf_pkg::tbf_state_t state;
		tbf_pkg::tbf_op_t op;
		tbf_pkg::tbf_word_t instr;
		tbf_pkg::tbf_word_t target;
		tbf_pkg::tbf_word_t block_number;
		tbf_pkg::tbf_word_t sum;
		logic [7:0] wcount;
		logic [1:0] chk_cnt;
		logic [`TBF_RUN_W-1:0] run;
		tbf_pkg::tbf_mark_t last_mark;
		tbf_pkg::tbf_word_t wshift;
		logic [2:0] write_bits;
		logic write_enable;
		logic [2:0] unit_select;
		logic reverse;
		logic motion_go;
		logic instr_ready;
		logic write_take;
		logic push_valid;
		tbf_pkg::tbf_word_t push_data;
		logic interblock_event;
		logic check_error;
		logic format_error;
		logic overrun;
		logic first_gap;
		logic op_done;
	} tbf_regs_t;

	tbf_regs_t s;
	tbf_regs_t next_s;
	tbf_pkg::tbf_mark_t mark;
	logic eval;
	logic reading;
	logic writing;
	tbf_stream_if #(.W(`TBF_WORD_W)) push_if ();

	// Octal decode of the operation digit
	function automatic tbf_pkg::tbf_op_t op_decode(input logic [2:0] d);
		case (d)
			`TBF_OPC_READ: op_decode = tbf_pkg::OP_READ;
			`TBF_OPC_CHECK: op_decode = tbf_pkg::OP_CHECK;
			`TBF_OPC_WRITE: op_decode = tbf_pkg::OP_WRITE;
			`TBF_OPC_WCG: op_decode = tbf_pkg::OP_WCG;
			default: op_decode = tbf_pkg::OP_NONE;
		endcase
	endfunction

	// Mark decoder looks only at the window register
	tbf_mark_decoder u_dec (
		.window(s.window), // RULE15
		.mark(mark)
	);

	// Read buffer; the processor may stall, overrun is flagged
	tbf_fifo #(.WIDTH(`TBF_WORD_W), .DEPTH(`TBF_FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.in_s(push_if.snk),
		.out_valid(read_valid),
		.out_ready(read_ready),
		.out_data(read_word)
	);

	assign push_if.valid = s.push_valid;
	assign push_if.data = s.push_data;

	// Word boundary: second pulse after the fourth line
	assign eval = s.pulse[1] && (s.line_cnt == 2'h0); // RULE3 RULE22
	assign reading = (s.op == tbf_pkg::OP_READ)
		|| (s.op == tbf_pkg::OP_CHECK);
	assign writing = (s.op == tbf_pkg::OP_WRITE)
		|| (s.op == tbf_pkg::OP_WCG);

	// Next state of the whole framer
	always_comb
	begin
		next_s = s;
		// Two-flop synchronisers for the tape channels
		next_s.t_sync = {s.t_sync[0], timing_channel};
		next_s.t_prev = s.t_sync[1];
		next_s.m_sync = {s.m_sync[0], mark_channel};
		next_s.d_s1 = data_channel;
		next_s.d_s2 = s.d_s1;
		// Timing edge starts a train of five tape pulses
		next_s.pulse = {s.pulse[`TBF_PULSES-2:0],
			s.t_sync[1] & ~s.t_prev}; // RULE14
		next_s.write_take = 1'b0;
		next_s.push_valid = 1'b0;
		next_s.interblock_event = 1'b0;
		next_s.op_done = 1'b0;

		// Pulse zero samples one line
		if (s.pulse[0])
		begin
			next_s.window = {s.window[2:0], s.m_sync[1]}; // RULE22
			next_s.asm_word = {s.asm_word[8:0], s.d_s2}; // RULE19
			next_s.line_cnt = s.line_cnt + 2'h1; // RULE3
		end

		// Pulse zero drives a line; a word loaded at eval fills the next
		// word's four lines, so data stays aligned with its mark word
		if (s.pulse[0] && s.write_enable) // RULE3
		begin
			next_s.write_bits = s.wshift[11:9];
			next_s.wshift = {s.wshift[8:0], 3'h0};
		end

		// Instruction intake, two words
		if (instr_valid && s.instr_ready)
		begin
			if (s.state == tbf_pkg::ST_IDLE)
			begin
				next_s.instr = instr_word; // RULE17
				next_s.op = op_decode(instr_word[2:0]); // RULE18
				next_s.unit_select =
					instr_word[`TBF_IW_UNIT_LSB +: 3]; // RULE16
				next_s.reverse = instr_word[`TBF_IW_REV]; // RULE16
				next_s.check_error = 1'b0;
				next_s.format_error = 1'b0;
				next_s.overrun = 1'b0;
				next_s.state = tbf_pkg::ST_SECOND;
			end
			else
			begin
				next_s.target = instr_word; // RULE17
				next_s.motion_go = 1'b1; // RULE16
				next_s.state = tbf_pkg::ST_SEARCH;
			end
		end

		// A dropped word cannot be reread, so it is only reported;
		// placed after the intake so a set beats a same-cycle clear
		if (s.push_valid && !push_if.ready)
			next_s.overrun = 1'b1;

		// Word decode drives motion and block sequencing
		if (eval)
		begin
			next_s.last_mark = mark;
			if (mark == s.last_mark && s.run != '1)
				next_s.run = s.run + 1'b1;
			else if (mark != s.last_mark)
				next_s.run = `TBF_RUN_W'(1);
			if (mark == tbf_pkg::MK_INTER
				&& s.run == `TBF_FIRST_INTER_WORDS - 1'b1)
				next_s.first_gap = 1'b1; // RULE13
			case (mark)
				tbf_pkg::MK_INTER:
				begin
					if (s.state != tbf_pkg::ST_IDLE && s.instr[`TBF_IW_IBZ])
						next_s.interblock_event = 1'b1; // RULE12
				end
				tbf_pkg::MK_END:
				begin
					if (s.motion_go && s.instr[`TBF_IW_ENDREV])
						next_s.reverse = ~s.reverse; // RULE21
					else if (s.motion_go)
					begin
						next_s.motion_go = 1'b0; // RULE21
						next_s.write_enable = 1'b0;
						next_s.op_done = 1'b1;
						next_s.state = tbf_pkg::ST_IDLE;
					end
				end
				tbf_pkg::MK_FWD, tbf_pkg::MK_REV:
				begin
					next_s.block_number = s.asm_word; // RULE4 RULE20
					if (s.state == tbf_pkg::ST_SEARCH
						|| s.state == tbf_pkg::ST_ARMED)
					begin
						next_s.state = tbf_pkg::ST_SEARCH;
						if (mark == tbf_pkg::MK_FWD && !s.reverse
							&& s.asm_word == s.target)
						begin
							next_s.state = tbf_pkg::ST_ARMED; // RULE4
							next_s.sum = '0; // RULE23
							next_s.wcount = '0;
						end
						else if (mark == tbf_pkg::MK_FWD && !s.reverse
							&& s.asm_word > s.target)
							next_s.reverse = 1'b1; // RULE16
						else if (mark == tbf_pkg::MK_REV && s.reverse
							&& s.asm_word < s.target)
							next_s.reverse = 1'b0; // RULE10
					end
				end
				tbf_pkg::MK_GUARD:
				begin
					// Mode switches here, clear of the number word
					if (s.state == tbf_pkg::ST_ARMED)
					begin
						next_s.state = tbf_pkg::ST_XFER; // RULE5
						if (writing)
						begin
							next_s.write_enable = 1'b1;
							next_s.wshift = write_word;
							next_s.write_take = 1'b1;
							next_s.sum = write_word; // RULE23
						end
					end
				end
				tbf_pkg::MK_DATA:
				begin
					if (s.state == tbf_pkg::ST_XFER)
					begin
						next_s.wcount = s.wcount + 8'h01; // RULE6
						if (reading)
							next_s.sum = s.sum + s.asm_word; // RULE23
						if (s.op == tbf_pkg::OP_READ)
						begin
							next_s.push_valid = 1'b1;
							next_s.push_data = s.asm_word; // RULE11
						end
						if (writing)
						begin
							next_s.wshift = write_word;
							next_s.write_take = 1'b1;
							next_s.sum = s.sum + write_word; // RULE23
						end
					end
				end
				tbf_pkg::MK_FINAL:
				begin
					if (s.state == tbf_pkg::ST_XFER)
					begin
						next_s.state = tbf_pkg::ST_CHECK; // RULE7
						next_s.chk_cnt = 2'h0;
						if (s.wcount != `TBF_DATA_WORDS)
							next_s.format_error = 1'b1; // RULE6
						if (reading)
							next_s.sum = s.sum + s.asm_word; // RULE23
						if (s.op == tbf_pkg::OP_READ)
						begin
							next_s.push_valid = 1'b1;
							next_s.push_data = s.asm_word;
						end
						if (writing)
							next_s.wshift = ~s.sum; // RULE8 RULE11
					end
				end
				tbf_pkg::MK_CHECK:
				begin
					if (s.state == tbf_pkg::ST_CHECK)
					begin
						next_s.chk_cnt = s.chk_cnt + 2'h1;
						if (s.chk_cnt == 2'h0)
						begin
							// Writers off long before the reverse number
							next_s.write_enable = 1'b0; // RULE9
							next_s.wshift = '0;
							if (reading && s.asm_word != ~s.sum)
								next_s.check_error = 1'b1; // RULE8 RULE11
						end
						if (s.chk_cnt == `TBF_CHECK_LAST)
						begin
							next_s.state = tbf_pkg::ST_IDLE; // RULE8
							next_s.motion_go = 1'b0;
							next_s.op_done = 1'b1;
						end
					end
				end
				default:
				begin
				end
			endcase
		end
		next_s.instr_ready = (next_s.state == tbf_pkg::ST_IDLE)
			|| (next_s.state == tbf_pkg::ST_SECOND);
	end

	// One register for all state; clock enable freezes everything
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else if (clk_en)
			s <= next_s;
	end

	// Outputs straight from the state register
	assign write_bits = s.write_bits;
	assign write_enable = s.write_enable;
	assign unit_select = s.unit_select;
	assign reverse = s.reverse;
	assign motion_go = s.motion_go;
	assign instr_ready = s.instr_ready;
	assign write_take = s.write_take;
	assign block_number = s.block_number;
	assign interblock_event = s.interblock_event;
	assign check_error = s.check_error;
	assign format_error = s.format_error;
	assign overrun = s.overrun;
	assign first_gap = s.first_gap;
	assign op_done = s.op_done;

	// Checks on the framer
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence q_pulse_train;
		s.pulse[1] ##1 s.pulse[2] ##1 s.pulse[3] ##1 s.pulse[4];
	endsequence

	property p_pulse_train;
		clk_en [*5] ##0 $rose(s.pulse[0]) |-> ##1 q_pulse_train;
	endproperty
	a_pulse_train: assert property (p_pulse_train) // RULE14
		else $error("tape pulse train broken");

	property p_final_to_check;
		clk_en && eval && mark == tbf_pkg::MK_FINAL
			&& s.state == tbf_pkg::ST_XFER |=> s.state == tbf_pkg::ST_CHECK;
	endproperty
	a_final_to_check: assert property (p_final_to_check) // RULE7
		else $error("final mark did not enter check zone");

	property p_end_stop;
		clk_en && eval && mark == tbf_pkg::MK_END && s.motion_go
			&& !s.instr[`TBF_IW_ENDREV] |=> !motion_go && op_done;
	endproperty
	a_end_stop: assert property (p_end_stop) // RULE21
		else $error("end zone did not stop transport");

	property p_check_error;
		clk_en && eval && mark == tbf_pkg::MK_CHECK
			&& s.state == tbf_pkg::ST_CHECK && s.chk_cnt == 2'h0
			&& reading && s.asm_word != ~s.sum |=> check_error;
	endproperty
	a_check_error: assert property (p_check_error) // RULE8
		else $error("bad checksum not flagged");

	property p_writers_off;
		clk_en && eval && mark == tbf_pkg::MK_CHECK
			&& s.state == tbf_pkg::ST_CHECK |=> !write_enable;
	endproperty
	a_writers_off: assert property (p_writers_off) // RULE9
		else $error("writers on in check zone");

	property p_interblock;
		clk_en && eval && mark == tbf_pkg::MK_INTER
			&& s.state != tbf_pkg::ST_IDLE && s.instr[`TBF_IW_IBZ]
			|=> interblock_event ##1 (!interblock_event || !clk_en);
	endproperty
	a_interblock: assert property (p_interblock) // RULE12
		else $error("interblock event missing or stuck");

	property p_second_word;
		clk_en && instr_valid && instr_ready
			&& s.state == tbf_pkg::ST_SECOND
			|=> s.target == $past(instr_word) && motion_go;
	endproperty
	a_second_word: assert property (p_second_word) // RULE17
		else $error("second instruction word not stored");

	property p_block_number;
		clk_en && eval && (mark == tbf_pkg::MK_FWD
			|| mark == tbf_pkg::MK_REV)
			|=> block_number == $past(s.asm_word);
	endproperty
	a_block_number: assert property (p_block_number) // RULE20
		else $error("block number not captured");

	property p_sum_clear;
		clk_en && eval && mark == tbf_pkg::MK_FWD && !s.reverse
			&& s.state == tbf_pkg::ST_SEARCH && s.asm_word == s.target
			|=> s.sum == '0 && s.state == tbf_pkg::ST_ARMED;
	endproperty
	a_sum_clear: assert property (p_sum_clear) // RULE23
		else $error("checksum not cleared at block start");
endmodule
`default_nettype wire

// [verif/tbf_tape_model.sv]
// Behavioural tape heads: play mark and data words onto the read channels
// and record what the block writes. Assumes a 160 ns line and a block
// that syncs the channels on its own clock.
`timescale 1ns/10ps
`default_nettype none
module tbf_tape_model (
	// Read heads
	output logic timing_channel,
	output logic mark_channel,
	output logic [2:0] data_channel,
	// Write heads
	input wire logic [2:0] write_bits
);
	// Last four lines written, oldest line in the top bits
	logic [11:0] last_written;

	// Timing track stands low outside frames
	initial
	begin
		timing_channel = 1'b0;
		mark_channel = 1'b0;
		data_channel = 3'h0;
		last_written = 12'h000;
	end

	// Bits settle 40 ns before the timing edge and hold to the line end,
	// well past the block's two-flop sync delay
	task automatic send_word(input logic [3:0] mark,
		input logic [11:0] data);
		for (int k = 0; k < 4; k++)
		begin
			mark_channel = mark[3 - k];
			data_channel = data[11 - 3 * k -: 3];
			#40;
			timing_channel = 1'b1;
			#80;
			last_written = {last_written[8:0], write_bits};
			timing_channel = 1'b0;
			#40;
		end
		// Released lines show the inverse so nothing stale passes
		mark_channel = ~mark_channel;
		data_channel = ~data_channel;
	endtask
endmodule
`default_nettype wire

// [verif/tbf_top_test.sv]
// Self-checking bench for the tape block format decoder.
// Assumes tbf_tape_model plays the tape; the processor side is driven here.
`timescale 1ns/10ps
`default_nettype none
`include "tbf_defines.svh"
`define CHK(what, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			n_mismatch++; \
			$display("[ERR] %s expected %h seen %h", what, exp, got); \
		end \
	end
module tbf_top_test;
	typedef struct {
		logic [11:0] w1;
		logic [11:0] w2;
		logic [3:0] mk;
		logic [11:0] num;
		logic rev;
		logic go;
	} tbf_row_t;
	logic clk_sys, rst_n, instr_valid, read_ready, we_mid;
	logic [11:0] instr_word, write_word, read_word, block_number;
	logic [11:0] first_wr, check_wr, rsum, wsum;
	logic [2:0] write_bits, unit_select, data_channel;
	logic timing_channel, mark_channel, write_enable, reverse, motion_go;
	logic instr_ready, write_take, read_valid, interblock_event;
	logic check_error, format_error, overrun, first_gap, op_done;
	int n_mismatch, comparisons, n_ib, n_done, n_take;
	tbf_row_t rows [6];

	tbf_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
		.timing_channel(timing_channel), .mark_channel(mark_channel),
		.data_channel(data_channel), .write_bits(write_bits),
		.write_enable(write_enable), .unit_select(unit_select),
		.reverse(reverse), .motion_go(motion_go),
		.instr_valid(instr_valid), .instr_word(instr_word),
		.instr_ready(instr_ready), .write_word(write_word),
		.write_take(write_take), .read_valid(read_valid),
		.read_ready(read_ready), .read_word(read_word),
		.block_number(block_number), .interblock_event(interblock_event),
		.check_error(check_error), .format_error(format_error),
		.overrun(overrun), .first_gap(first_gap), .op_done(op_done));

	tbf_tape_model i_tape (.timing_channel(timing_channel),
		.mark_channel(mark_channel), .data_channel(data_channel),
		.write_bits(write_bits));

	// 100 MHz system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Event counters; new write word supplied after each take
	always @(posedge clk_sys)
	begin
		if (interblock_event === 1'b1)
			n_ib++;
		if (op_done === 1'b1)
			n_done++;
		if (write_take === 1'b1)
		begin
			n_take++;
			write_word <= write_word + 12'h0A5;
		end
	end

	// Data pattern played onto tape
	function automatic logic [11:0] dw(input int i);
		return 12'(i * 13 + 5);
	endfunction

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Go and ready outputs must sit at zero through reset; also reused mid-run
	task automatic reset_dut();
		rst_n = 1'b0;
		repeat (5) @(posedge clk_sys);
		`CHK("idle go", 1'b0, motion_go)
		`CHK("idle ready", 1'b0, instr_ready)
		#1;
		rst_n = 1'b1;
		n_ib = 0;
		n_done = 0;
		n_take = 0;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("ready after reset", 1'b1, instr_ready)
	endtask

	// Two words back to back; ready must fall once the pair is in
	task automatic give_instr(input logic [11:0] w1, input logic [11:0] w2);
		@(posedge clk_sys);
		#1;
		instr_valid = 1'b1;
		instr_word = w1;
		@(posedge clk_sys);
		#1;
		instr_word = w2;
		@(posedge clk_sys);
		#1;
		instr_valid = 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK("ready after pair", 1'b0, instr_ready)
		`CHK("unit", w1[5:3], unit_select)
	endtask

	// Whole standard block; snapshots of the write heads along the way
	task automatic send_block(input logic [11:0] num, input logic [11:0] ck);
		i_tape.send_word(`TBF_MK_FWD, num);
		i_tape.send_word(`TBF_MK_GUARD, 12'h000);
		for (int i = 0; i < 255; i++)
		begin
			i_tape.send_word(`TBF_MK_DATA, dw(i));
			if (i == 0)
			begin
				first_wr = i_tape.last_written;
				we_mid = write_enable;
			end
		end
		i_tape.send_word(`TBF_MK_FINAL, dw(255));
		i_tape.send_word(`TBF_MK_CHECK, ck);
		check_wr = i_tape.last_written;
		i_tape.send_word(`TBF_MK_CHECK, 12'h000);
		i_tape.send_word(`TBF_MK_CHECK, 12'h000);
		i_tape.send_word(`TBF_MK_REV, num);
	endtask

	// Main sequence: table of search and end-zone cases, then whole blocks
	initial
	begin
		instr_valid = 1'b0;
		instr_word = 12'h000;
		read_ready = 1'b0;
		write_word = 12'h000;
		n_mismatch = 0;
		comparisons = 0;
		rows = '{'{12'h0A8, 12'h040, `TBF_MK_FWD, 12'h050, 1'b1, 1'b1},
			'{12'h110, 12'h040, `TBF_MK_END, 12'h000, 1'b1, 1'b1},
			'{12'h018, 12'h040, `TBF_MK_END, 12'h000, 1'b0, 1'b0},
			'{12'h048, 12'h040, `TBF_MK_REV, 12'h030, 1'b0, 1'b1},
			'{12'h040, 12'h040, `TBF_MK_REV, 12'h050, 1'b1, 1'b1},
			'{12'h00D, 12'h040, `TBF_MK_FWD, 12'h030, 1'b0, 1'b1}};
		rsum = 12'h000;
		wsum = 12'h000;
		for (int i = 0; i < 256; i++)
		begin
			rsum += dw(i);
			wsum += 12'h3C0 + i * 12'h0A5;
		end
		foreach (rows[r])
		begin
			reset_dut();
			give_instr(rows[r].w1, rows[r].w2);
			i_tape.send_word(rows[r].mk, rows[r].num);
			`CHK("reverse", rows[r].rev, reverse)
			`CHK("go", rows[r].go, motion_go)
			`CHK("number", rows[r].num, block_number)
			`CHK("done", rows[r].go ? 0 : 1, n_done)
		end
		// Read with the consumer stalled: fill, refuse, then drain
		reset_dut();
		give_instr(12'h0A8, 12'h012);
		repeat (5) i_tape.send_word(`TBF_MK_INTER, 12'h000);
		`CHK("interblock", 5, n_ib)
		`CHK("no first gap", 1'b0, first_gap)
		send_block(12'h012, ~rsum);
		`CHK("read done", 1, n_done)
		`CHK("sum ok", 1'b0, check_error)
		`CHK("framing", 1'b0, format_error)
		`CHK("overrun", 1'b1, overrun)
		`CHK("block", 12'h012, block_number)
		@(posedge clk_sys);
		#1;
		read_ready = 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			`CHK("read valid", 1'b1, read_valid)
			`CHK("read word", dw(i), read_word)
			@(posedge clk_sys);
			#1;
		end
		`CHK("drained", 1'b0, read_valid)
		read_ready = 1'b0;
		// Check pass against a sum recorded true instead of complemented
		give_instr(12'h001, 12'h012);
		send_block(12'h012, rsum);
		`CHK("sum bad", 1'b1, check_error)
		`CHK("check done", 2, n_done)
		// Write one block from a rising word sequence
		reset_dut();
		write_word = 12'h3C0;
		give_instr(12'h004, 12'h020);
		send_block(12'h020, 12'h000);
		`CHK("writers on", 1'b1, we_mid)
		`CHK("first written", 12'h3C0, first_wr)
		`CHK("sum written", ~wsum, check_wr)
		`CHK("takes", 256, n_take)
		`CHK("writers off", 1'b0, write_enable)
		`CHK("write done", 1, n_done)
		results();
	end

	// Watchdog: the tests need about 0.5 ms of tape
	initial
	begin
		#1000000;
		n_mismatch++;
		results();
	end
endmodule
`default_nettype wire
